// ===== hdl/prsc_pkg.sv
// shared constants and types of the power-on reset and standby controller
package prsc_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_POWER_WAIT,
    ST_LOAD,
    ST_RELEASE,
    ST_USER
  } prsc_state_type;

  // bit positions in the synchronised monitor vector
  localparam int unsigned SYNC_VCCINT_UP  = 0;
  localparam int unsigned SYNC_VCCIO_UP   = 1;
  localparam int unsigned SYNC_BELOW_PR   = 2;
  localparam int unsigned SYNC_BELOW_LP   = 3;
  localparam int unsigned SYNC_EXT_UP     = 4;
  localparam int unsigned SYNC_PLL_BASE   = 5;

  // reset values
  localparam prsc_state_type RST_STATE = ST_POWER_WAIT;
  localparam logic RST_IO_HIZ     = 1'b1;
  localparam logic RST_CFG_DONE   = 1'b0;
  localparam logic RST_USER_RSTN  = 1'b0;
  localparam logic RST_LOAD_START = 1'b0;
  localparam logic RST_BANDGAP_EN = 1'b1;
  localparam logic RST_MON_PR_EN  = 1'b1;
  localparam logic RST_OSC_EN     = 1'b1;
  localparam logic RST_PLL_EN     = 1'b1;
  localparam logic RST_BANK_EN    = 1'b1;
  localparam logic RST_CLK_NET_EN = 1'b0;
  localparam logic RST_INBUF_EN   = 1'b1;
  localparam logic RST_STANDBY    = 1'b0;
  localparam logic RST_WAKE_OPT   = 1'b0;
  localparam logic RST_SYNC       = 1'b0;

endpackage : prsc_pkg

// ===== hdl/prsc_por_standby_ctrl.sv
// power-on reset sequencer and standby power control
// How it works
// - all supplies past rise threshold start the flash configuration load
// - user I/Os stay high impedance until configuration has finished
// - optional user-mode monitor resets and restarts on core supply fall
// - bandgap off also turns off monitor, PLLs, oscillator, referenced buffers
// - bandgap may turn off only on 1.2 V core variants
// - PLL powers down only once all its output clocks are low
// - referenced and differential buffers switch off per bank at run time
// - each primary clock net has its own run-time enable
// - power guard switches off any input buffer, also in standby
// - oscillator can be disabled statically and turns off in standby
// - each PLL can be disabled statically and turns off in standby
// - with bandgap off a low-power monitor stays active and trips
// - regulator variants also watch the external supply
// - serial bus wake and standby requests stay quiet unless wake option set
module prsc_por_standby_ctrl
  import prsc_pkg::*;
#(
  parameter int unsigned NUM_PLL       = 2,
  parameter int unsigned NUM_BANK      = 4,
  parameter int unsigned NUM_CLK_NET   = 8,
  parameter int unsigned NUM_IN_BUF    = 8,
  parameter bit          CORE_1V2      = 1'b1,
  parameter bit          HAS_REGULATOR = 1'b0
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_vccint_up,
  input  wire logic                   i_vccio_up,
  input  wire logic                   i_vcc_ext_up,
  input  wire logic                   i_vccint_below_pr,
  input  wire logic                   i_vccint_below_lp,
  input  wire logic [NUM_PLL-1:0]     i_pll_outs_low,
  input  wire logic                   i_cfg_load_done,
  input  wire logic                   i_wake_opt_cfg,
  input  wire logic                   i_monitor_en,
  input  wire logic                   i_standby_req,
  input  wire logic                   i_bandgap_off_req,
  input  wire logic                   i_monitor_off_req,
  input  wire logic                   i_osc_static_off,
  input  wire logic [NUM_PLL-1:0]     i_pll_static_off,
  input  wire logic [NUM_BANK-1:0]    i_bank_ref_off,
  input  wire logic [NUM_CLK_NET-1:0] i_clk_net_en,
  input  wire logic [NUM_IN_BUF-1:0]  i_inbuf_guard,
  input  wire logic                   i_sbus_wake,
  input  wire logic                   i_sbus_stdby,
  output logic                        o_cfg_load_start,
  output logic                        o_io_hiz,
  output logic                        o_cfg_done,
  output logic                        o_user_rst_n,
  output logic                        o_standby,
  output logic                        o_bandgap_en,
  output logic                        o_monitor_pr_en,
  output logic                        o_osc_en,
  output logic [NUM_PLL-1:0]          o_pll_en,
  output logic [NUM_BANK-1:0]         o_bank_ref_en,
  output logic [NUM_CLK_NET-1:0]      o_clk_net_en,
  output logic [NUM_IN_BUF-1:0]       o_inbuf_en,
  output logic                        o_wake_to_pwr,
  output logic                        o_stdby_to_pwr
);

  localparam int unsigned SYNC_W = SYNC_PLL_BASE + NUM_PLL;

  prsc_state_type         state_q, state_d;
  logic                   load_start_q, load_start_d;
  logic                   io_hiz_q, io_hiz_d;
  logic                   cfg_done_q, cfg_done_d;
  logic                   user_rstn_q, user_rstn_d;
  logic                   stby_q, stby_d;
  logic                   bg_en_q, bg_en_d;
  logic                   mon_pr_q, mon_pr_d;
  logic                   osc_en_q, osc_en_d;
  logic [NUM_PLL-1:0]     pll_en_q, pll_en_d;
  logic [NUM_BANK-1:0]    bank_en_q, bank_en_d;
  logic [NUM_CLK_NET-1:0] net_en_q, net_en_d;
  logic [NUM_IN_BUF-1:0]  inbuf_q, inbuf_d;
  logic                   wake_opt_q, wake_opt_d;
  logic                   wake_out_q, wake_out_d;
  logic                   stdby_out_q, stdby_out_d;
  logic                   all_up;
  logic                   precise_on;
  logic                   trip;
  logic                   in_user;
  logic                   sbus_wake;
  logic                   sbus_stdby;
  logic [SYNC_W-1:0]      mon;

  prsc_sync_if #(.W(SYNC_W)) u_sync_bus ();

  assign u_sync_bus.raw = {i_pll_outs_low, i_vcc_ext_up, i_vccint_below_lp,
                           i_vccint_below_pr, i_vccio_up, i_vccint_up};
  assign mon = u_sync_bus.clean;

  prsc_sync3 #(.W(SYNC_W)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .sbus      (u_sync_bus.filt)
  );

  // supply checks
  always_comb begin
    all_up = mon[SYNC_VCCINT_UP] & mon[SYNC_VCCIO_UP]
             & (~HAS_REGULATOR | mon[SYNC_EXT_UP]);
    precise_on = bg_en_q & mon_pr_q;
    trip = (precise_on & i_monitor_en & mon[SYNC_BELOW_PR])
           | (~precise_on & mon[SYNC_BELOW_LP])
           | (HAS_REGULATOR & i_monitor_en & ~mon[SYNC_EXT_UP]);
    in_user = (state_q == ST_USER);
    sbus_wake = wake_opt_q & i_sbus_wake;
    sbus_stdby = wake_opt_q & i_sbus_stdby;
  end

  // power-up sequence
  always_comb begin
    state_d      = state_q;
    load_start_d = 1'b0;
    wake_opt_d   = wake_opt_q;
    unique case (state_q)
      ST_POWER_WAIT: begin
        if (all_up) begin
          state_d      = ST_LOAD;
          load_start_d = 1'b1;
        end
      end
      ST_LOAD: begin
        if (!all_up) begin
          state_d = ST_POWER_WAIT;
        end else if (i_cfg_load_done) begin
          state_d    = ST_RELEASE;
          wake_opt_d = i_wake_opt_cfg;
        end
      end
      ST_RELEASE: begin
        state_d = all_up ? ST_USER : ST_POWER_WAIT;
      end
      ST_USER: begin
        if (trip) begin
          state_d    = ST_POWER_WAIT;
          wake_opt_d = RST_WAKE_OPT;
        end
      end
    endcase
    io_hiz_d    = (state_d != ST_USER);
    cfg_done_d  = (state_d == ST_RELEASE) || (state_d == ST_USER);
    user_rstn_d = (state_d == ST_USER);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q      <= RST_STATE;
      load_start_q <= RST_LOAD_START;
      wake_opt_q   <= RST_WAKE_OPT;
      io_hiz_q     <= RST_IO_HIZ;
      cfg_done_q   <= RST_CFG_DONE;
      user_rstn_q  <= RST_USER_RSTN;
    end else begin
      state_q      <= state_d;
      load_start_q <= load_start_d;
      wake_opt_q   <= wake_opt_d;
      io_hiz_q     <= io_hiz_d;
      cfg_done_q   <= cfg_done_d;
      user_rstn_q  <= user_rstn_d;
    end
  end

  // standby and power gating
  always_comb begin
    stby_d = in_user & (i_standby_req | sbus_stdby | (stby_q & ~sbus_wake));
    bg_en_d = ~(CORE_1V2 & stby_q & i_bandgap_off_req & (pll_en_q == '0));
    mon_pr_d = bg_en_d & ~(stby_q & i_monitor_off_req);
    osc_en_d = bg_en_d & ~i_osc_static_off & ~stby_q;
    for (int i = 0; i < NUM_PLL; i++) begin
      if (i_pll_static_off[i] | stby_q | ~bg_en_q) begin
        pll_en_d[i] = pll_en_q[i] & ~mon[SYNC_PLL_BASE+i];
      end else begin
        pll_en_d[i] = 1'b1;
      end
    end
    bank_en_d   = ~i_bank_ref_off & {NUM_BANK{bg_en_d}};
    net_en_d    = in_user ? i_clk_net_en : '0;
    inbuf_d     = ~i_inbuf_guard;
    wake_out_d  = sbus_wake;
    stdby_out_d = sbus_stdby;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stby_q      <= RST_STANDBY;
      bg_en_q     <= RST_BANDGAP_EN;
      mon_pr_q    <= RST_MON_PR_EN;
      osc_en_q    <= RST_OSC_EN;
      pll_en_q    <= {NUM_PLL{RST_PLL_EN}};
      bank_en_q   <= {NUM_BANK{RST_BANK_EN}};
      net_en_q    <= {NUM_CLK_NET{RST_CLK_NET_EN}};
      inbuf_q     <= {NUM_IN_BUF{RST_INBUF_EN}};
      wake_out_q  <= RST_WAKE_OPT;
      stdby_out_q <= RST_WAKE_OPT;
    end else begin
      stby_q      <= stby_d;
      bg_en_q     <= bg_en_d;
      mon_pr_q    <= mon_pr_d;
      osc_en_q    <= osc_en_d;
      pll_en_q    <= pll_en_d;
      bank_en_q   <= bank_en_d;
      net_en_q    <= net_en_d;
      inbuf_q     <= inbuf_d;
      wake_out_q  <= wake_out_d;
      stdby_out_q <= stdby_out_d;
    end
  end

  assign o_cfg_load_start = load_start_q;
  assign o_io_hiz         = io_hiz_q;
  assign o_cfg_done       = cfg_done_q;
  assign o_user_rst_n     = user_rstn_q;
  assign o_standby        = stby_q;
  assign o_bandgap_en     = bg_en_q;
  assign o_monitor_pr_en  = mon_pr_q;
  assign o_osc_en         = osc_en_q;
  assign o_pll_en         = pll_en_q;
  assign o_bank_ref_en    = bank_en_q;
  assign o_clk_net_en     = net_en_q;
  assign o_inbuf_en       = inbuf_q;
  assign o_wake_to_pwr    = wake_out_q;
  assign o_stdby_to_pwr   = stdby_out_q;

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_done_rise;
    $rose(o_cfg_done) && !o_user_rst_n;
  endsequence

  sequence s_released;
    o_user_rst_n && !o_io_hiz;
  endsequence

  chk_load_on_rise: assert property (
    (state_q == ST_POWER_WAIT) && all_up |=> o_cfg_load_start && (state_q == ST_LOAD))
    else $error("configuration load not started after supplies rose");

  chk_io_hiz_config: assert property (
    !o_cfg_done || !o_user_rst_n |-> o_io_hiz)
    else $error("user I/O released before configuration finished");

  chk_brownout_reset: assert property (
    in_user && trip |=> !o_user_rst_n && o_io_hiz && (state_q == ST_POWER_WAIT))
    else $error("supply fall in user mode did not reset");

  chk_bandgap_chain: assert property (
    !o_bandgap_en |-> !o_monitor_pr_en && !o_osc_en && (o_pll_en == '0)
                      && (o_bank_ref_en == '0))
    else $error("analog block left on with bandgap off");

  chk_bandgap_variant: assert property (
    !o_bandgap_en |-> CORE_1V2 && $past(o_standby))
    else $error("bandgap turned off where not allowed");

  for (genvar g = 0; g < NUM_PLL; g++) begin : g_pll_chk
    chk_pll_wait_low: assert property (
      $fell(o_pll_en[g]) |-> $past(mon[SYNC_PLL_BASE+g]))
      else $error("PLL powered off while an output clock was high");
  end

  chk_release_delay: assert property (
    s_done_rise |=> s_released)
    else $error("user reset not released one clock after done");

  chk_wake_gated: assert property (
    !wake_opt_q |=> !o_wake_to_pwr && !o_stdby_to_pwr)
    else $error("serial bus power request passed without wake option");

  chk_lowpower_trip: assert property (
    in_user && !precise_on && mon[SYNC_BELOW_LP] |=> !o_user_rst_n ##1 !o_cfg_done)
    else $error("low-power monitor did not trip with precise monitor off");

  chk_osc_standby: assert property (
    o_standby |=> !o_osc_en)
    else $error("oscillator still on in standby");

endmodule : prsc_por_standby_ctrl

// ===== hdl/prsc_sync3.sv
// three-stage synchroniser with agreement filter for outside levels
module prsc_sync3
  import prsc_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic  i_ref_clk,
  input  wire logic  i_rstn,
  prsc_sync_if.filt  sbus
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;
  logic [W-1:0] clean_d;

  // a bit changes only when stages two and three agree
  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s2_q[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q    <= {W{RST_SYNC}};
      s2_q    <= {W{RST_SYNC}};
      s3_q    <= {W{RST_SYNC}};
      clean_q <= {W{RST_SYNC}};
    end else begin
      s1_q    <= sbus.raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign sbus.clean = clean_q;

endmodule : prsc_sync3

// ===== hdl/prsc_sync_if.sv
// raw and cleaned monitor levels between the controller and its synchroniser
interface prsc_sync_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport feed (output raw, input clean);
  modport filt (input raw, output clean);
endinterface : prsc_sync_if

// ===== verification/prsc_far_model.sv
// far side model: configuration flash and pll clock-low flags
module prsc_far_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_load_start,
  output logic            o_load_done,
  output logic [1:0]      o_pll_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       busy_q;
  logic [2:0] ph_q;
  // flash done pulse a few cycles after start; each pll low two cycles in eight
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      o_load_done <= 1'b0;
      ph_q <= 3'h0;
      o_pll_low <= 2'b00;
    end else begin
      ph_q <= ph_q + 3'h1;
      o_pll_low <= {ph_q[2:1] == 2'b01, ph_q[2:1] == 2'b11};
      o_load_done <= busy_q && (cnt_q == 4'h6);
      if (i_load_start) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'h6) begin
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule : prsc_far_model

// ===== verification/prsc_por_standby_ctrl_tb.sv
// self-checking testbench of the power-on reset and standby controller
module prsc_por_standby_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, vint = 1'b0, vio = 1'b0, blw_pr = 1'b0, blw_lp = 1'b0;
  logic wk_opt = 1'b0, mon_en = 1'b0, sreq = 1'b0, bg_off = 1'b0, mon_off = 1'b0;
  logic osc_off = 1'b0, swake = 1'b0, sstdby = 1'b0;
  logic [1:0] pll_off = 2'b00;
  logic [3:0] bank_off = 4'h0;
  logic [7:0] net_en = 8'hff, guard = 8'h00;
  logic done, start, hiz, cfg_done, urst_n, stby, bg_en, mon_pr, osc_en, wk_out, sb_out;
  logic [1:0] pll_low, pll_en;
  logic [3:0] bank_en;
  logic [7:0] net_out, inb_en;
  int fails = 0, check_count = 0, n;
  always #5 clk = ~clk;
  prsc_far_model prsc_far_model_inst (.i_ref_clk(clk), .i_rstn(rstn),
    .i_load_start(start), .o_load_done(done), .o_pll_low(pll_low));
  prsc_por_standby_ctrl prsc_por_standby_ctrl_inst (.i_ref_clk(clk), .i_rstn(rstn),
    .i_vccint_up(vint), .i_vccio_up(vio), .i_vcc_ext_up(1'b1), .i_vccint_below_pr(blw_pr),
    .i_vccint_below_lp(blw_lp), .i_pll_outs_low(pll_low), .i_cfg_load_done(done),
    .i_wake_opt_cfg(wk_opt), .i_monitor_en(mon_en), .i_standby_req(sreq),
    .i_bandgap_off_req(bg_off), .i_monitor_off_req(mon_off), .i_osc_static_off(osc_off),
    .i_pll_static_off(pll_off), .i_bank_ref_off(bank_off), .i_clk_net_en(net_en),
    .i_inbuf_guard(guard), .i_sbus_wake(swake), .i_sbus_stdby(sstdby),
    .o_cfg_load_start(start), .o_io_hiz(hiz), .o_cfg_done(cfg_done), .o_user_rst_n(urst_n),
    .o_standby(stby), .o_bandgap_en(bg_en), .o_monitor_pr_en(mon_pr), .o_osc_en(osc_en),
    .o_pll_en(pll_en), .o_bank_ref_en(bank_en), .o_clk_net_en(net_out),
    .o_inbuf_en(inb_en), .o_wake_to_pwr(wk_out), .o_stdby_to_pwr(sb_out));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic power_up(input logic wk);
    @(posedge clk);
    vint <= 1'b1;
    vio <= 1'b1;
    wk_opt <= wk;
    for (n = 0; n < 20 && start !== 1'b1; n++) tick(1);
    chk("load_start", 8'h01, start);
    chk("hiz_load", 8'h01, hiz);
    for (n = 0; n < 20 && cfg_done !== 1'b1; n++) tick(1);
    chk("cfg_done", 8'h01, cfg_done);
    chk("rstn_at_done", 8'h00, urst_n);
    chk("hiz_at_done", 8'h01, hiz);
    tick(1);
    chk("rstn_user", 8'h01, urst_n);
    chk("hiz_user", 8'h00, hiz);
  endtask : power_up
  task automatic sbus_try(input logic on);
    @(posedge clk);
    sstdby <= 1'b1;
    tick(1);
    chk("stdby_out", {7'h00, on}, sb_out);
    chk("standby_sbus", {7'h00, on}, stby);
    @(posedge clk);
    sstdby <= 1'b0;
    swake <= 1'b1;
    tick(1);
    chk("wake_out", {7'h00, on}, wk_out);
    chk("standby_woke", 8'h00, stby);
    @(posedge clk);
    swake <= 1'b0;
  endtask : sbus_try
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    chk("net_pre_user", 8'h00, net_out);
    chk("hiz_pre_cfg", 8'h01, hiz);
    chk("bg_reset", 8'h01, bg_en);
    power_up(1'b0);
    sbus_try(1'b0);
    @(posedge clk);
    bank_off <= 4'h5;
    net_en <= 8'h3c;
    guard <= 8'h81;
    osc_off <= 1'b1;
    pll_off <= 2'b01;
    tick(1);
    chk("bank_ref", 8'h0a, bank_en);
    chk("net_en", 8'h3c, net_out);
    chk("inbuf", 8'h7e, inb_en);
    for (n = 0; n < 40 && pll_en !== 2'b10; n++) tick(1);
    chk("pll_static", 8'h02, pll_en);
    chk("osc_static", 8'h00, osc_en);
    @(posedge clk);
    bank_off <= 4'h0;
    osc_off <= 1'b0;
    pll_off <= 2'b00;
    tick(2);
    chk("pll_back", 8'h03, pll_en);
    @(posedge clk);
    sreq <= 1'b1;
    bg_off <= 1'b1;
    mon_off <= 1'b1;
    for (n = 0; n < 5 && stby !== 1'b1; n++) tick(1);
    tick(1);
    chk("osc_stby", 8'h00, osc_en);
    for (n = 0; n < 40 && pll_en !== 2'b00; n++) tick(1);
    chk("pll_stby", 8'h00, pll_en);
    chk("bg_wait", 8'h01, bg_en);
    tick(1);
    chk("bg_off", 8'h00, bg_en);
    chk("mon_off", 8'h00, mon_pr);
    chk("bank_bg", 8'h00, bank_en);
    @(posedge clk);
    blw_lp <= 1'b1;
    vint <= 1'b0;
    for (n = 0; n < 10 && urst_n !== 1'b0; n++) tick(1);
    chk("lp_trip", 8'h00, urst_n);
    chk("lp_hiz", 8'h01, hiz);
    @(posedge clk);
    blw_lp <= 1'b0;
    sreq <= 1'b0;
    bg_off <= 1'b0;
    mon_off <= 1'b0;
    tick(2);
    chk("bg_back", 8'h01, bg_en);
    chk("osc_back", 8'h01, osc_en);
    power_up(1'b1);
    sbus_try(1'b1);
    @(posedge clk);
    mon_en <= 1'b1;
    blw_pr <= 1'b1;
    for (n = 0; n < 10 && urst_n !== 1'b0; n++) tick(1);
    chk("pr_trip", 8'h00, urst_n);
    chk("pr_hiz", 8'h01, hiz);
    chk("pr_done", 8'h00, cfg_done);
    finish_test();
  end
  initial begin
    #50us;
    fails++;
    finish_test();
  end
endmodule : prsc_por_standby_ctrl_tb
